// [hdl/dce_regs.vh]
// register offsets, field positions and reset values of the checksum engine
`ifndef DCE_REGS_VH
`define DCE_REGS_VH
`define DCE_OFF_CONTROL   4'h0
`define DCE_OFF_RESULT    4'h4
`define DCE_OFF_TAPS      4'h8
`define DCE_BYTE_ORDER_HI 29
`define DCE_BYTE_ORDER_LO 28
`define DCE_WRITE_REORDER 27
`define DCE_BIT_REFLECT   24
`define DCE_POLY_LENGTH_MINUS_ONE_HI       12
`define DCE_POLY_LENGTH_MINUS_ONE_LO       8
`define DCE_ENABLE        7
`define DCE_APPEND        6
`define DCE_ALGO          5
`define DCE_CHAN_HI       2
`define DCE_CHAN_LO       0
`define DCE_CONTROL_MASK  32'h3900_1FE7
`define DCE_RESET_VALUE   32'h0000_0000
`define DCE_RESP_OKAY     2'b00
`define DCE_RESP_SLVERR   2'b10
`endif

// [hdl/dce_engine.v]
// checksum engine in the dma datapath with an axi4-lite register slave
// Overview of operation
// R1 - byte order 00 none, 01 word reverse, 10 half-word swap, 11 bytes in half-words
// R2 - write-reorder set writes reordered data to destination, else data unaltered
// R3 - while write-reorder is set, append mode is held clear
// R4 - bit reflect 1 processes lsb first, 0 msb first, both algorithms
// R5 - polynomial length field holds length minus one; ignored in ip mode
// R6 - enable routes assigned channel through engine; clear means plain transfer
// R7 - append mode: data not written; result written to destination start at block end
// R8 - append clear: data passes through engine and is written, honouring write-reorder
// R9 - algorithm bit 1 selects ip header checksum, 0 selects lfsr crc
// R10 - three-bit channel select assigns the engine to one of eight channels
// R11 - writing the result register seeds the generator
// R12 - result read gives current state, bits above polynomial length read zero
// R13 - ip mode result holds 16 bits, upper 16 read zero
// R14 - ip mode writes converted and reads return ones'-complement value
// R15 - each tap bit enables feedback xor into its stage, else plain shift
// R16 - tap register ignored in ip header mode
// R17 - unimplemented control bits read zero, all fields reset to zero
// R18 - ip checksum is ones'-complement sum of half-words with end-around carry
// R19 - lfsr advances one bit per step, feedback from bit at polynomial length
//
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/100ps
`include "dce_regs.vh"

module dce_engine #(
  parameter DATA_W = 32
) (
  input  wire              i_clk,
  input  wire              i_rst_n,
  input  wire              i_ce,
  // axi4-lite slave
  input  wire [3:0]        i_awaddr,
  input  wire              i_awvalid,
  output wire              o_awready,
  input  wire [31:0]       i_wdata,
  input  wire [3:0]        i_wstrb,
  input  wire              i_wvalid,
  output wire              o_wready,
  output reg  [1:0]        o_bresp,
  output reg               o_bvalid,
  input  wire              i_bready,
  input  wire [3:0]        i_araddr,
  input  wire              i_arvalid,
  output wire              o_arready,
  output reg  [31:0]       o_rdata,
  output reg  [1:0]        o_rresp,
  output reg               o_rvalid,
  input  wire              i_rready,
  // channel datapath
  input  wire [2:0]        i_xfer_channel,
  input  wire              i_xfer_valid,
  input  wire [DATA_W-1:0] i_xfer_data,
  input  wire              i_xfer_block_done,
  input  wire [31:0]       i_channel_dest_start_address,
  output reg               o_dest_write,
  output reg  [DATA_W-1:0] o_dest_data,
  output reg  [31:0]       o_dest_addr_override,
  output reg               o_dest_use_override,
  output wire              o_checksum_enable
);

  reg  [31:0] control;
  reg  [31:0] crc_state;
  reg  [31:0] crc_feedback_taps;
  reg         aw_held;
  reg  [3:0]  aw_addr;
  reg         w_held;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;

  wire [1:0] byte_order_select     = control[`DCE_BYTE_ORDER_HI:`DCE_BYTE_ORDER_LO];
  wire       write_reorder         = control[`DCE_WRITE_REORDER];
  wire       bit_reflect           = control[`DCE_BIT_REFLECT];
  wire [4:0] poly_length_minus_one = control[`DCE_POLY_LENGTH_MINUS_ONE_HI:`DCE_POLY_LENGTH_MINUS_ONE_LO];
  wire       checksum_enable       = control[`DCE_ENABLE];
  wire       append_mode           = control[`DCE_APPEND];
  wire       algorithm_select      = control[`DCE_ALGO];
  wire [2:0] channel_select        = control[`DCE_CHAN_HI:`DCE_CHAN_LO];

  assign o_checksum_enable = checksum_enable;

  // engine only sees the assigned channel while enabled
  wire hit = i_ce & i_xfer_valid & checksum_enable & (i_xfer_channel == channel_select); // R6 R10

  // byte reordering of the source word
  reg [31:0] ordered;
  always @* begin
    case (byte_order_select) // R1
      2'b01:   ordered = {i_xfer_data[7:0], i_xfer_data[15:8],
                          i_xfer_data[23:16], i_xfer_data[31:24]};
      2'b10:   ordered = {i_xfer_data[15:0], i_xfer_data[31:16]};
      2'b11:   ordered = {i_xfer_data[23:16], i_xfer_data[31:24],
                          i_xfer_data[7:0], i_xfer_data[15:8]};
      default: ordered = i_xfer_data;
    endcase
  end

  // reflected mode feeds bits lsb first by mirroring the word
  reg [31:0] feed;
  integer k;
  always @* begin
    feed = ordered;
    if (bit_reflect) begin // R4
      for (k = 0; k < 32; k = k + 1)
        feed[k] = ordered[31-k];
    end
  end

  // lfsr: 32 single-bit steps, msb of the feed word first
  reg [31:0] lfsr_next;
  reg        fb;
  integer s, b;
  always @* begin
    lfsr_next = crc_state;
    fb = 1'b0;
    for (s = 31; s >= 0; s = s - 1) begin
      fb = lfsr_next[poly_length_minus_one] ^ feed[s]; // R19 R5
      for (b = 31; b > 0; b = b - 1)
        lfsr_next[b] = crc_feedback_taps[b] ? (lfsr_next[b-1] ^ fb) : lfsr_next[b-1]; // R15
      lfsr_next[0] = crc_feedback_taps[0] ? fb : 1'b0; // R15
    end
  end

  // ip checksum: two half-words with end-around carry; taps unused
  wire [17:0] sum_raw = {2'b00, crc_state[15:0]} + {2'b00, feed[31:16]}
                        + {2'b00, feed[15:0]}; // R18 R16
  wire [16:0] sum_fold = {1'b0, sum_raw[15:0]} + {15'h0000, sum_raw[17:16]};
  wire [15:0] ip_next  = sum_fold[15:0] + {15'h0000, sum_fold[16]};

  // readable result masked by polynomial length or ip width
  reg [31:0] len_mask;
  integer m;
  always @* begin
    for (m = 0; m < 32; m = m + 1)
      len_mask[m] = (m <= poly_length_minus_one);
  end
  wire [31:0] result_view = algorithm_select ? {16'h0000, ~crc_state[15:0]} // R13 R14
                                             : (crc_state & len_mask); // R12

  // write channel: address and data taken in either order
  assign o_awready = ~aw_held & ~o_bvalid;
  assign o_wready  = ~w_held & ~o_bvalid;
  assign o_arready = ~o_rvalid;

  wire       aw_take  = i_awvalid & o_awready;
  wire       w_take   = i_wvalid & o_wready;
  wire       aw_now   = aw_held | aw_take;
  wire       w_now    = w_held | w_take;
  wire [3:0] wr_addr  = aw_held ? aw_addr : i_awaddr;
  wire [31:0] wr_data = w_held ? w_data : i_wdata;
  wire [3:0] wr_strb  = w_held ? w_strb : i_wstrb;
  wire       wr_fire  = i_ce & aw_now & w_now & ~o_bvalid;
  wire       wr_ok    = (wr_addr == `DCE_OFF_CONTROL) | (wr_addr == `DCE_OFF_RESULT)
                      | (wr_addr == `DCE_OFF_TAPS);

  // byte-lane merge of write data
  function [31:0] merge;
    input [31:0] old;
    input [31:0] val;
    input [3:0]  st;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1)
        merge[i*8 +: 8] = st[i] ? val[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  wire [31:0] ctl_merge = merge(control, wr_data, wr_strb) & `DCE_CONTROL_MASK; // R17
  // append can never coexist with write-reorder
  wire [31:0] ctl_new = ctl_merge[`DCE_WRITE_REORDER] ?
                        (ctl_merge & ~(32'h0000_0001 << `DCE_APPEND)) : ctl_merge; // R3
  // ip mode seed converted from ones'-complement view
  wire [31:0] seed_view = merge(result_view, wr_data, wr_strb);
  wire [31:0] seed_new  = algorithm_select ? {16'h0000, ~seed_view[15:0]} : seed_view; // R14

  // bus handshake state
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_held  <= 1'b0;
      aw_addr  <= 4'h0;
      w_held   <= 1'b0;
      w_data   <= 32'h0000_0000;
      w_strb   <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp  <= `DCE_RESP_OKAY;
    end else if (i_ce) begin
      if (wr_fire) begin
        aw_held  <= 1'b0;
        w_held   <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp  <= wr_ok ? `DCE_RESP_OKAY : `DCE_RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_held <= 1'b1;
          aw_addr <= i_awaddr;
        end
        if (w_take) begin
          w_held <= 1'b1;
          w_data <= i_wdata;
          w_strb <= i_wstrb;
        end
        if (o_bvalid && i_bready)
          o_bvalid <= 1'b0;
      end
    end
  end

  // read channel, one cycle answer
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h0000_0000;
      o_rresp  <= `DCE_RESP_OKAY;
    end else if (i_ce) begin
      if (i_arvalid && o_arready) begin
        o_rvalid <= 1'b1;
        o_rresp  <= `DCE_RESP_OKAY;
        case (i_araddr)
          `DCE_OFF_CONTROL: o_rdata <= control;
          `DCE_OFF_RESULT:  o_rdata <= result_view; // R12
          `DCE_OFF_TAPS:    o_rdata <= crc_feedback_taps;
          default: begin
            o_rdata <= 32'h0000_0000;
            o_rresp <= `DCE_RESP_SLVERR;
          end
        endcase
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // registers and engine state; a seed write wins over a data step
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      control           <= `DCE_RESET_VALUE; // R17
      crc_state         <= `DCE_RESET_VALUE;
      crc_feedback_taps <= `DCE_RESET_VALUE;
    end else if (i_ce) begin
      if (wr_fire && wr_addr == `DCE_OFF_CONTROL)
        control <= ctl_new;
      if (wr_fire && wr_addr == `DCE_OFF_TAPS)
        crc_feedback_taps <= merge(crc_feedback_taps, wr_data, wr_strb);
      if (wr_fire && wr_addr == `DCE_OFF_RESULT)
        crc_state <= seed_new; // R11
      else if (hit)
        crc_state <= algorithm_select ? {16'h0000, ip_next} : lfsr_next; // R9
    end
  end

  // destination side: pass-through, reorder or append result
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_dest_write         <= 1'b0;
      o_dest_data          <= 32'h0000_0000;
      o_dest_addr_override <= 32'h0000_0000;
      o_dest_use_override  <= 1'b0;
    end else if (i_ce) begin
      o_dest_write        <= 1'b0;
      o_dest_use_override <= 1'b0;
      if (hit && i_xfer_block_done && append_mode) begin
        // last unit is folded in before the result goes out
        o_dest_write         <= 1'b1; // R7
        o_dest_use_override  <= 1'b1;
        o_dest_addr_override <= i_channel_dest_start_address;
        o_dest_data          <= algorithm_select ? {16'h0000, ~ip_next}
                                                 : (lfsr_next & len_mask);
      end else if (hit && !append_mode) begin
        o_dest_write <= 1'b1; // R8
        o_dest_data  <= write_reorder ? ordered : i_xfer_data; // R2
      end else if (i_xfer_valid && !hit) begin
        o_dest_write <= 1'b1; // R6
        o_dest_data  <= i_xfer_data;
      end
    end
  end

endmodule // dce_engine

// [dv/dce_engine_props.sv]
// assertion checker bound to the checksum engine ports
`timescale 1ns/100ps
`include "dce_regs.vh"
module dce_engine_props #(parameter DATA_W = 32) (
  input wire i_clk, i_rst_n, i_ce, i_awvalid, o_awready, i_wvalid, o_wready,
  input wire o_bvalid, i_bready, i_arvalid, o_arready, o_rvalid, i_rready,
  input wire i_xfer_valid, i_xfer_block_done, o_dest_write, o_dest_use_override,
  input wire o_checksum_enable,
  input wire [3:0] i_araddr,
  input wire [1:0] o_bresp, o_rresp,
  input wire [31:0] o_rdata, i_channel_dest_start_address, o_dest_addr_override,
  input wire [DATA_W-1:0] i_xfer_data, o_dest_data
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // handshakes as the slave sees them taken
  sequence wr_both; i_awvalid && o_awready && i_wvalid && o_wready && i_ce; endsequence
  sequence rd_take; i_arvalid && o_arready && i_ce; endsequence
  chk_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped early");
  chk_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped early");
  chk_write_answer: assert property (wr_both |=> o_bvalid) else $error("no write response");
  chk_read_answer: assert property (rd_take |=> o_rvalid) else $error("no read data");
  chk_ar_refuse: assert property (o_rvalid |-> !o_arready) else $error("read taken while busy");
  chk_unmapped_read: assert property (rd_take ##0 i_araddr[3:2] == 2'b11 |=>
    o_rresp == `DCE_RESP_SLVERR && o_rdata == 32'h0000_0000) else $error("bad unmapped read");
  chk_dest_cause: assert property (o_dest_write |-> $past(i_xfer_valid))
    else $error("destination write without a unit");
  chk_plain_pass: assert property (i_xfer_valid && i_ce && !o_checksum_enable |=>
    o_dest_write && o_dest_data == $past(i_xfer_data)) else $error("disabled unit altered");
  chk_append_addr: assert property (o_dest_use_override |-> o_dest_write &&
    $past(i_xfer_block_done) && o_dest_addr_override == $past(i_channel_dest_start_address))
    else $error("append result misplaced");
endmodule // dce_engine_props
bind dce_engine dce_engine_props #(.DATA_W(DATA_W)) u_props (.*);

// [dv/dce_xfer_src.sv]
// partner model: dma channel source handing units to the engine
`timescale 1ns/100ps
module dce_xfer_src (
  input  wire         i_clk, i_rst_n, i_go, i_slow,
  input  wire  [2:0]  i_chan,
  input  wire  [3:0]  i_len,
  input  wire  [31:0] i_seed,
  output logic        o_valid, o_done, o_busy,
  output logic [2:0]  o_chan,
  output logic [31:0] o_data
);
  logic [31:0] x;
  logic [3:0]  cnt;
  logic        gap;
  // one unit a cycle, or every other cycle when slow; data not held between units
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {o_valid, o_done, o_busy, gap, cnt, o_chan, o_data, x} <= '0;
    end else begin
      o_valid <= 1'b0;
      o_done <= 1'b0;
      gap <= i_slow & ~gap;
      o_data <= ~o_data;
      if (i_go && !o_busy) begin
        o_busy <= 1'b1;
        cnt <= i_len;
        x <= i_seed;
        o_chan <= i_chan;
      end else if (o_busy && !gap) begin
        o_valid <= 1'b1;
        o_data <= x;
        o_done <= cnt == 4'h1;
        o_busy <= cnt != 4'h1;
        cnt <= cnt - 4'h1;
        x <= x ^ (x << 13) ^ (x >> 7);
      end
    end
  end
endmodule // dce_xfer_src

// [dv/dce_engine_tb.sv]
// self-checking bench for the checksum engine with a behavioural model
`timescale 1ns/100ps
`include "dce_regs.vh"
module dce_engine_tb;
  logic clk = 0, rst_n = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, go = 0, slow = 0;
  logic [3:0] awaddr = 0, araddr = 0, len = 1;
  logic [31:0] wdata = 0, seed = 32'h0000_0032, sd = 0, ctl = 0, taps = 0, st = 0, exp_d = 0;
  logic [31:0] rdata, ddata, daddr, xdata, r, w, v;
  logic [2:0] chan = 0, xchan;
  logic [1:0] bresp, rresp;
  logic bvalid, rvalid, awready, wready, arready, dwr, dov, xv, xdone, busy, en;
  logic exp_w = 0, exp_ov = 0;
  logic [31:0] exp_a = 0;
  int error_cnt = 0, checks = 0;
  dce_engine dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_awaddr(awaddr),
    .i_awvalid(awv), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wv),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arv), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_xfer_channel(xchan),
    .i_xfer_valid(xv), .i_xfer_data(xdata), .i_xfer_block_done(xdone),
    .i_channel_dest_start_address(sd), .o_dest_write(dwr), .o_dest_data(ddata),
    .o_dest_addr_override(daddr), .o_dest_use_override(dov), .o_checksum_enable(en));
  dce_xfer_src src_u (.i_clk(clk), .i_rst_n(rst_n), .i_go(go), .i_slow(slow), .i_chan(chan),
    .i_len(len), .i_seed(wdata), .o_valid(xv), .o_done(xdone), .o_busy(busy),
    .o_chan(xchan), .o_data(xdata));
  initial forever #20 clk = ~clk;
  function logic [31:0] rnd();
    seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5; rnd = seed;
  endfunction
  function logic [31:0] ro(input logic [31:0] d);
    case (ctl[29:28])
      2'b01: ro = {d[7:0], d[15:8], d[23:16], d[31:24]};
      2'b10: ro = {d[15:0], d[31:16]};
      2'b11: ro = {d[23:16], d[31:24], d[7:0], d[15:8]};
      default: ro = d;
    endcase
  endfunction
  // ip mode keeps the raw sum, so a read shows it inverted
  function logic [31:0] res();
    res = ctl[5] ? {16'h0000, ~st[15:0]} : st & ~(32'hFFFF_FFFE << ctl[12:8]);
  endfunction
  function logic [31:0] upd(input logic [31:0] s, d);
    logic [16:0] t;
    logic        fb;
    w = ro(d);
    if (ctl[24]) for (int i = 0; i < 32; i++) r[i] = w[31-i]; else r = w;
    if (ctl[5]) begin
      t = s[15:0] + r[15:0]; t = t[15:0] + t[16]; t = t[15:0] + r[31:16];
      upd = t[15:0] + t[16];
    end else begin
      for (int i = 31; i >= 0; i--) begin fb = s[ctl[12:8]] ^ r[i]; s = (s << 1) ^ (taps & {32{fb}}); end
      upd = s;
    end
  endfunction
  task chk(input logic [31:0] s, e);
    checks++;
    if (s !== e) begin error_cnt++; $display("[FAIL] %0t seen %h expected %h", $time, s, e); end
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ready raised only once the answer shows, so the slave must hold it
  task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a; wdata <= d; awv <= 1; wv <= 1;
    forever begin
      @(posedge clk);
      if (awv && awready) awv <= 0;
      if (wv && wready) wv <= 0;
      if (bvalid && bready) break;
      if (bvalid) bready <= 1;
    end
    bready <= 0;
    chk(bresp, er);
    if (er == 0) case (a)
      4'h0: begin ctl = d & `DCE_CONTROL_MASK; if (d[27]) ctl[6] = 0; end
      4'h4: st = ctl[5] ? {16'h0000, ~d[15:0]} : d;
      default: taps = d;
    endcase
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a; arv <= 1;
    forever begin
      @(posedge clk);
      if (arv && arready) arv <= 0;
      if (rvalid && rready) break;
      if (rvalid) rready <= 1;
    end
    rready <= 0;
    chk(rdata, e);
    chk(rresp, er);
  endtask
  // model of the datapath, compared one cycle after each unit
  always @(posedge clk) if (rst_n) begin
    chk(dwr, exp_w);
    if (exp_w) chk(ddata, exp_d);
    chk(dov, exp_ov);
    if (exp_ov) chk(daddr, exp_a);
    exp_w = 0; exp_ov = 0; exp_a = sd;
    if (xv && ctl[7] && xchan == ctl[2:0]) begin
      st = upd(st, xdata);
      exp_w = !ctl[6] || xdone; exp_ov = ctl[6] && xdone;
      exp_d = ctl[6] ? res() : ctl[27] ? ro(xdata) : xdata;
    end else if (xv) begin exp_w = 1; exp_d = xdata; end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1;
    rd(4'h0, 0, 0); rd(4'h4, 0, 0); rd(4'h8, 0, 0);
    wr(4'h0, 32'hFFFF_FFFF, 0); rd(4'h0, 32'h3900_1FA7, 0);
    wr(4'hC, 0, `DCE_RESP_SLVERR); rd(4'hC, 0, `DCE_RESP_SLVERR);
    for (int k = 0; k < 24; k++) begin
      v = rnd(); v[2:0] = k[2:0]; v[29:28] = k[1:0]; v[7] = k != 23;
      wr(4'h0, v, 0); rd(4'h0, ctl, 0); chk(en, ctl[7]);
      wr(4'h8, rnd(), 0); wr(4'h4, rnd(), 0); rd(4'h4, res(), 0);
      sd <= rnd(); chan <= k == 22 ? ~k[2:0] : k[2:0]; len <= 4'(rnd() % 8 + 1);
      slow <= k[0]; go <= 1;
      @(posedge clk); go <= 0; @(posedge clk);
      while (busy) @(posedge clk);
      repeat (2) @(posedge clk);
      rd(4'h4, res(), 0);
    end
    give_verdict;
  end
  initial begin repeat (6000) @(posedge clk); error_cnt++; give_verdict; end
endmodule // dce_engine_tb
